// ### verilog/plc_operating_mode_sequencer.v
// Overview of operation
// - exactly one of stop, start-up, run, hold is active at once
// - stop runs no program, run indicator off once the blink window ends, stop indicator on
// - entering stop keeps counters, timers, flags and images untouched
// - stop asserts output inhibit, disabling all digital outputs
// - leaving stop enters start-up and calls the start-up handler
// - the start-up handler has no execution-time supervision
// - start-up keeps output inhibit asserted and stop indicator off
// - run indicator blinks at least 3 s from handler start, even into stop
// - start-up handler completion switches mode to run
// - run repeats main cycle block; interrupt sections may be inserted
// - run keeps timers and counters going, image refreshed each cycle
// - run releases inhibit, run indicator steady once the blink window ends, stop indicator off
// - up to three breakpoints, set and cleared by the station
// - reaching an armed breakpoint in run enters hold, registers shown
// - hold accepts single-step or resume; resume runs to next breakpoint
// - hold blinks run indicator and keeps stop indicator on
// - hold halts all code execution at every priority level
// - hold freezes program timers while the real-time clock counts
// - hold asserts output inhibit, communication connections stay up
// - with more than two breakpoints single-step is refused
// - breakpoints usable any time, no separate test mode needed
// - start clears input image, calls handler, then clears outputs in the cycle inhibit releases
// - each run cycle reads inputs, runs main block, writes outputs
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "mode_seq_defines.vh"

module plc_operating_mode_sequencer #(
    parameter [31:0] STARTUP_BLINK_CYC = `STARTUP_BLINK_CYC,
    parameter [31:0] BLINK_HALF_CYC    = `BLINK_HALF_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        startup_done,
    input  wire        main_done,
    input  wire        bp_reached,
    input  wire        stmt_done,
    input  wire        error_detect,
    output reg         startup_handler_call_q,
    output reg         main_cycle_run_q,
    output reg         step_grant_q,
    output reg         clr_input_image_q,
    output reg         clr_output_image_q,
    output reg         read_input_image_q,
    output reg         write_output_image_q,
    output reg         timers_run_q,
    output reg         regs_visible_q,
    output reg         output_inhibit_q,
    output reg         run_indicator_q,
    output reg         stop_indicator_q,
    output reg  [1:0]  mode_q
);

    // ======================================================================
    // decoding helpers
    function is_reg;
        input [31:0] a;
        begin
            is_reg = (a[31:5] == 27'h0) && (a[1:0] == 2'h0) &&
                     (a[4:2] <= 3'h5);
        end
    endfunction

    // ======================================================================
    // state
    reg  [1:0]  mode_d;
    reg  [1:0]  phase_q;
    reg  [1:0]  phase_d;
    reg  [1:0]  bp_count_q;
    reg         bp_arm_q;
    reg         step_ref_q;
    reg         step_busy_q;
    reg  [31:0] timer_q;
    reg  [31:0] rtc_q;
    reg  [31:0] cycles_q;
    reg         startup_kick;
    reg         step_take;
    reg         step_refuse;
    reg         cycle_end;
    wire        blink;
    wire        blink_min;
    wire        wr_acc;
    wire [7:0]  waddr;
    wire        start_req;
    wire        stop_req;
    wire        step_req;
    wire        resume_req;
    wire        ref_clear;
    wire [31:0] status_word;

    assign wr_acc     = psel && penable && pwrite && pready &&
                        is_reg(paddr);
    assign waddr      = paddr[7:0];
    assign start_req  = wr_acc && (waddr == `REG_CTRL) &&
                        pwdata[`CTRL_START];
    assign stop_req   = wr_acc && (waddr == `REG_CTRL) &&
                        pwdata[`CTRL_STOP];
    assign step_req   = wr_acc && (waddr == `REG_CTRL) &&
                        pwdata[`CTRL_STEP];
    assign resume_req = wr_acc && (waddr == `REG_CTRL) &&
                        pwdata[`CTRL_RESUME];
    assign ref_clear  = wr_acc && (waddr == `REG_STATUS) &&
                        pwdata[`ST_STEP_REF];

    assign status_word = {21'h0, phase_q, regs_visible_q, bp_arm_q,
                          step_ref_q, blink_min, stop_indicator_q,
                          run_indicator_q, output_inhibit_q, mode_q};

    // ======================================================================
    // blink source
    indicator_blinker #(
        .MIN_CYC  (STARTUP_BLINK_CYC),
        .HALF_CYC (BLINK_HALF_CYC)
    ) u_blink (
        .pclk         (pclk),
        .presetn      (presetn),
        .start        (startup_kick),
        .blink_q      (blink),
        .min_active_q (blink_min)
    );

    // ======================================================================
    // mode and phase selection
    always @* begin
        mode_d       = mode_q;
        phase_d      = phase_q;
        startup_kick = 1'b0;
        step_take    = 1'b0;
        step_refuse  = 1'b0;
        cycle_end    = 1'b0;
        case (mode_q)
        `MODE_STOP: begin
            if (start_req) begin
                mode_d       = `MODE_STARTUP;
                startup_kick = 1'b1;
            end
        end
        `MODE_STARTUP: begin
            if (error_detect || stop_req) begin
                mode_d = `MODE_STOP;
            end else if (startup_done) begin
                mode_d  = `MODE_RUN;
                phase_d = `PH_CLR_OUT;
            end
        end
        `MODE_RUN: begin
            if (error_detect || stop_req) begin
                mode_d = `MODE_STOP;
            end else begin
                case (phase_q)
                `PH_CLR_OUT: phase_d = `PH_READ;
                `PH_READ:    phase_d = `PH_MAIN;
                `PH_MAIN: begin
                    if (bp_reached && bp_arm_q &&
                        (bp_count_q != 2'h0)) begin
                        mode_d = `MODE_HOLD;
                    end else if (main_done) begin
                        phase_d = `PH_WRITE;
                    end
                end
                `PH_WRITE: begin
                    phase_d   = `PH_READ;
                    cycle_end = 1'b1;
                end
                default:     phase_d = `PH_READ;
                endcase
            end
        end
        `MODE_HOLD: begin
            if (stop_req) begin
                mode_d = `MODE_STOP;
            end else if (resume_req) begin
                mode_d = `MODE_RUN;
            end else if (step_req && !step_busy_q) begin
                if (bp_count_q > `BP_STEP_MAX) begin
                    step_refuse = 1'b1;
                end else begin
                    step_take = 1'b1;
                end
            end
        end
        default: mode_d = `MODE_STOP;
        endcase
    end

    // ======================================================================
    // mode registers and sequencing outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q                 <= `MODE_STOP;
            phase_q                <= `PH_CLR_OUT;
            startup_handler_call_q <= 1'b0;
            main_cycle_run_q       <= 1'b0;
            step_grant_q           <= 1'b0;
            step_busy_q            <= 1'b0;
            clr_input_image_q      <= 1'b0;
            clr_output_image_q     <= 1'b0;
            read_input_image_q     <= 1'b0;
            write_output_image_q   <= 1'b0;
            timers_run_q           <= 1'b0;
            regs_visible_q         <= 1'b0;
            output_inhibit_q       <= 1'b1;
            run_indicator_q        <= 1'b0;
            stop_indicator_q       <= 1'b1;
            cycles_q               <= 32'h0000_0000;
        end else begin
            mode_q  <= mode_d;
            phase_q <= phase_d;
            // stop leaves images, timers and counters alone
            clr_input_image_q      <= startup_kick;
            startup_handler_call_q <= (mode_d == `MODE_STARTUP) &&
                                      !startup_kick;
            clr_output_image_q     <= (mode_q == `MODE_STARTUP) &&
                                      (mode_d == `MODE_RUN);
            read_input_image_q     <= (mode_d == `MODE_RUN) &&
                                      (phase_d == `PH_READ) &&
                                      (phase_q != `PH_READ);
            write_output_image_q   <= (mode_d == `MODE_RUN) &&
                                      (phase_d == `PH_WRITE);
            main_cycle_run_q       <= (mode_d == `MODE_RUN) &&
                                      (phase_d == `PH_MAIN);
            timers_run_q           <= (mode_d == `MODE_RUN);
            regs_visible_q         <= (mode_d == `MODE_HOLD);
            output_inhibit_q       <= (mode_d !=
                                      `MODE_RUN);
            stop_indicator_q       <= (mode_d == `MODE_STOP) ||
                                      (mode_d == `MODE_HOLD);
            step_grant_q           <= step_take;
            if (step_take) begin
                step_busy_q <= 1'b1;
            end else if (stmt_done || mode_d != `MODE_HOLD) begin
                step_busy_q <= 1'b0;
            end
            if (cycle_end) begin
                cycles_q <= cycles_q + 32'h0000_0001;
            end
            if (blink_min || startup_kick) begin
                run_indicator_q <= blink;
            end else begin
                case (mode_d)
                `MODE_STOP:    run_indicator_q <= 1'b0;
                `MODE_STARTUP: run_indicator_q <= blink;
                `MODE_RUN:     run_indicator_q <= 1'b1;
                `MODE_HOLD:    run_indicator_q <= blink;
                default:       run_indicator_q <= 1'b0;
                endcase
            end
        end
    end

    // ======================================================================
    // program timer and real-time clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_q <= 32'h0000_0000;
            rtc_q   <= 32'h0000_0000;
        end else begin
            rtc_q <= rtc_q + 32'h0000_0001;
            if (timers_run_q) begin
                timer_q <= timer_q + 32'h0000_0001;
            end
        end
    end

    // ======================================================================
    // breakpoint set-up and step refusal flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_count_q <= 2'h0;
            bp_arm_q   <= 1'b0;
            step_ref_q <= 1'b0;
        end else begin
            if (wr_acc && waddr == `REG_BPCOUNT) begin
                bp_count_q <= (pwdata[31:0] > {30'h0, `BP_MAX}) ?
                              `BP_MAX : pwdata[1:0];
            end
            if (wr_acc && waddr == `REG_CTRL) begin
                bp_arm_q <= pwdata[`CTRL_BP_ARM];
            end
            if (step_refuse) begin
                step_ref_q <= 1'b1;
            end else if (ref_clear) begin
                step_ref_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // apb slave, zero wait states, data latched in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !is_reg(paddr);
                case (paddr[7:0])
                `REG_CTRL:    prdata <= {27'h0, bp_arm_q, 4'h0};
                `REG_STATUS:  prdata <= status_word;
                `REG_BPCOUNT: prdata <= {30'h0, bp_count_q};
                `REG_TIMER:   prdata <= timer_q;
                `REG_RTC:     prdata <= rtc_q;
                `REG_CYCLES:  prdata <= cycles_q;
                default:      prdata <= 32'h0000_0000;
                endcase
                if (!is_reg(paddr)) begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

endmodule // plc_operating_mode_sequencer

// ### verilog/mode_seq_defines.vh
`ifndef MODE_SEQ_DEFINES_VH
`define MODE_SEQ_DEFINES_VH

// ==========================================================================
// register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_BPCOUNT     8'h08
`define REG_TIMER       8'h0c
`define REG_RTC         8'h10
`define REG_CYCLES      8'h14

// ==========================================================================
// control fields, write one to act; the bp arm bit takes the value written
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_STEP       2
`define CTRL_RESUME     3
`define CTRL_BP_ARM     4

// ==========================================================================
// status fields
`define ST_MODE_LO      0
`define ST_MODE_HI      1
`define ST_INHIBIT      2
`define ST_RUN_IND      3
`define ST_STOP_IND     4
`define ST_BLINK_MIN    5
`define ST_STEP_REF     6
`define ST_BP_ARM       7
`define ST_REGS_VIS     8
`define ST_PHASE_LO     9
`define ST_PHASE_HI     10

// ==========================================================================
// modes and run phases
`define MODE_STOP       2'h0
`define MODE_STARTUP    2'h1
`define MODE_RUN        2'h2
`define MODE_HOLD       2'h3
`define PH_CLR_OUT      2'h0
`define PH_READ         2'h1
`define PH_MAIN         2'h2
`define PH_WRITE        2'h3

// ==========================================================================
// reset values, limits and timing
`define CTRL_RESET      32'h0000_0000
`define BP_MAX          2'h3
`define BP_STEP_MAX     2'h2
`define CLK_HZ          20000000
`define STARTUP_BLINK_MS 3000
`define BLINK_HALF_MS   250
`define STARTUP_BLINK_CYC (`STARTUP_BLINK_MS * (`CLK_HZ / 1000))
`define BLINK_HALF_CYC  (`BLINK_HALF_MS * (`CLK_HZ / 1000))

`endif

// ### verilog/indicator_blinker.v
`timescale 1ns/100ps
`include "mode_seq_defines.vh"

// ==========================================================================
// blink phase and minimum start-up blink window
module indicator_blinker #(
    parameter [31:0] MIN_CYC  = `STARTUP_BLINK_CYC,
    parameter [31:0] HALF_CYC = `BLINK_HALF_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        start,
    output reg         blink_q,
    output reg         min_active_q
);

    reg [31:0] min_cnt_q;
    reg [31:0] half_cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_cnt_q    <= 32'h0000_0000;
            min_active_q <= 1'b0;
            half_cnt_q   <= 32'h0000_0000;
            blink_q      <= 1'b0;
        end else begin
            if (start) begin
                min_cnt_q    <= 32'h0000_0001;
                min_active_q <= 1'b1;
            end else if (min_active_q) begin
                if (min_cnt_q >= MIN_CYC) begin
                    min_active_q <= 1'b0;
                end else begin
                    min_cnt_q <= min_cnt_q + 32'h0000_0001;
                end
            end
            if (half_cnt_q >= HALF_CYC - 32'h0000_0001) begin
                half_cnt_q <= 32'h0000_0000;
                blink_q    <= ~blink_q;
            end else begin
                half_cnt_q <= half_cnt_q + 32'h0000_0001;
            end
        end
    end

endmodule // indicator_blinker

// ### verification/plc_seq_props.sv
`timescale 1ns/100ps
// ==========================================================================
// mode sequencer properties
module plc_seq_props (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire       pwrite,
    input wire       startup_done,
    input wire       main_done,
    input wire       bp_reached,
    input wire       error_detect,
    input wire       startup_handler_call_q,
    input wire       main_cycle_run_q,
    input wire       step_grant_q,
    input wire       clr_input_image_q,
    input wire       clr_output_image_q,
    input wire       read_input_image_q,
    input wire       write_output_image_q,
    input wire       timers_run_q,
    input wire       regs_visible_q,
    input wire       output_inhibit_q,
    input wire       stop_indicator_q,
    input wire [1:0] mode_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_leave_stop;
        mode_q == 2'h0 ##1 mode_q == 2'h1;
    endsequence
    sequence s_handler_call;
        clr_input_image_q && !startup_handler_call_q ##1 startup_handler_call_q;
    endsequence
    property p_stop_out;
        mode_q == 2'h0 |-> output_inhibit_q && stop_indicator_q
            && !main_cycle_run_q && !timers_run_q;
    endproperty
    property p_startup_out;
        mode_q == 2'h1 |-> output_inhibit_q && !stop_indicator_q;
    endproperty
    property p_run_out;
        mode_q == 2'h2 |-> !output_inhibit_q && !stop_indicator_q
            && timers_run_q;
    endproperty
    property p_hold_out;
        mode_q == 2'h3 |-> output_inhibit_q && stop_indicator_q
            && regs_visible_q && !timers_run_q && !main_cycle_run_q;
    endproperty
    property p_startup_seq;
        s_leave_stop |-> s_handler_call;
    endproperty
    property p_done_run;
        mode_q == 2'h1 && startup_done && !error_detect
            && !(psel && penable && pwrite)
            |=> mode_q == 2'h2 && clr_output_image_q;
    endproperty
    property p_err_stop;
        (mode_q == 2'h1 || mode_q == 2'h2) && error_detect
            |=> mode_q == 2'h0 && output_inhibit_q;
    endproperty
    property p_hold_entry;
        mode_q != 2'h3 ##1 mode_q == 2'h3
            |-> $past(mode_q) == 2'h2 && $past(bp_reached);
    endproperty
    property p_step;
        step_grant_q |-> mode_q == 2'h3 ##1 !step_grant_q;
    endproperty
    property p_cycle_write;
        main_done && main_cycle_run_q && mode_q == 2'h2 && !error_detect
            |-> ##[1:2] write_output_image_q;
    endproperty
    property p_rd_in;
        (clr_output_image_q || write_output_image_q) && !error_detect
            |=> read_input_image_q;
    endproperty
    a_stop_out: assert property (p_stop_out)
        else $error("stop mode outputs wrong");
    a_startup_out: assert property (p_startup_out)
        else $error("start-up outputs wrong");
    a_run_out: assert property (p_run_out)
        else $error("run mode outputs wrong");
    a_hold_out: assert property (p_hold_out)
        else $error("hold mode outputs wrong");
    a_startup_seq: assert property (p_startup_seq)
        else $error("start-up entry missing handler call");
    a_done_run: assert property (p_done_run)
        else $error("handler done did not enter run");
    a_err_stop: assert property (p_err_stop)
        else $error("error did not force stop");
    a_hold_entry: assert property (p_hold_entry)
        else $error("hold entered without breakpoint in run");
    a_step: assert property (p_step)
        else $error("step grant outside hold or too long");
    a_cycle_write: assert property (p_cycle_write)
        else $error("output image not written after main pass");
    a_rd_in: assert property (p_rd_in)
        else $error("no input read");
endmodule // plc_seq_props

bind plc_operating_mode_sequencer plc_seq_props i_plc_seq_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .startup_done, .main_done,
    .bp_reached, .error_detect, .startup_handler_call_q, .main_cycle_run_q,
    .step_grant_q, .clr_input_image_q, .clr_output_image_q,
    .read_input_image_q, .write_output_image_q, .timers_run_q,
    .regs_visible_q, .output_inhibit_q, .stop_indicator_q, .mode_q);

// ### verification/core_model.sv
`timescale 1ns/100ps
// ==========================================================================
// program core standing behind the sequencer
module core_model #(
    parameter integer SU_DLY   = 40,
    parameter integer MAIN_LEN = 6
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        bp_en,
    input  wire        startup_handler_call_q,
    input  wire        main_cycle_run_q,
    input  wire        step_grant_q,
    output reg         startup_done,
    output reg         main_done,
    output reg         bp_reached,
    output reg         stmt_done
);
    integer su_cnt;
    integer mn_cnt;
    reg     bp_used;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {startup_done, main_done, bp_reached, stmt_done} <= 4'h0;
            su_cnt <= 0;
            mn_cnt <= 0;
            bp_used <= 1'b0;
        end else begin
            startup_done <= 1'b0;
            main_done <= 1'b0;
            bp_reached <= 1'b0;
            stmt_done <= step_grant_q;
            // unsupervised handler, may take long
            if (startup_handler_call_q) begin
                su_cnt <= su_cnt + 1;
                startup_done <= (su_cnt == SU_DLY);
            end else begin
                su_cnt <= 0;
            end
            if (main_cycle_run_q && !main_done) begin
                mn_cnt <= (mn_cnt == MAIN_LEN) ? 0 : mn_cnt + 1;
                main_done <= (mn_cnt == MAIN_LEN);
                if (bp_en && !bp_used && mn_cnt == 1) begin
                    bp_reached <= 1'b1;
                    bp_used <= 1'b1;
                end
            end else begin
                mn_cnt <= 0;
            end
            if (!bp_en) bp_used <= 1'b0;
        end
    end
endmodule // core_model

// ### verification/tb.sv
`timescale 1ns/100ps
`include "mode_seq_defines.vh"
// ==========================================================================
// testbench top
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd, t0;
    logic        error_detect, bp_en, su_done, m_done, bp_hit, s_done;
    logic        su_call, m_run, grant, inh, tmr, vis, run_ind, stop_ind;
    logic [1:0]  mode;
    logic        ri_prev = 1'b0;
    int          mismatches, samples_checked, cycles, grants, toggles, g, c0;

    plc_operating_mode_sequencer #(.STARTUP_BLINK_CYC(32'd200),
        .BLINK_HALF_CYC(32'd10)) i_plc_operating_mode_sequencer (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .startup_done(su_done), .main_done(m_done),
        .bp_reached(bp_hit), .stmt_done(s_done), .error_detect,
        .startup_handler_call_q(su_call), .main_cycle_run_q(m_run),
        .step_grant_q(grant), .clr_input_image_q(), .clr_output_image_q(),
        .read_input_image_q(), .write_output_image_q(), .timers_run_q(tmr),
        .regs_visible_q(vis), .output_inhibit_q(inh),
        .run_indicator_q(run_ind), .stop_indicator_q(stop_ind),
        .mode_q(mode));
    core_model i_core_model (.pclk, .presetn, .bp_en,
        .startup_handler_call_q(su_call), .main_cycle_run_q(m_run),
        .step_grant_q(grant), .startup_done(su_done), .main_done(m_done),
        .bp_reached(bp_hit), .stmt_done(s_done));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (grant === 1'b1) grants++;
        if (run_ind !== ri_prev) toggles++;
        ri_prev = run_ind;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ======================================================================
    // tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd & mask, exp);
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 2000) begin
            n++;
            @(posedge pclk);
        end
        check("mode", {30'h0, mode}, {30'h0, m});
    endtask
    task automatic end_of_test;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, error_detect, bp_en, presetn} = 6'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk("status", `REG_STATUS, 32'h1f, 32'h14);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        apb(1'b1, `REG_BPCOUNT, 32'h5);
        rd_chk("bpcount", `REG_BPCOUNT, 32'h3, 32'h3);
        apb(1'b1, `REG_BPCOUNT, 32'h2);
        apb(1'b1, `REG_CTRL, 32'h1);
        c0 = cycles;
        wait_mode(`MODE_STARTUP);
        repeat (3) @(posedge pclk);
        check("startup", {29'h0, su_call, inh, stop_ind}, 32'h6);
        wait_mode(`MODE_RUN);
        check("run", {29'h0, inh, tmr, stop_ind}, 32'h2);
        check("blink", {31'h0, toggles >= 3}, 32'h1);
        while (cycles - c0 < 190) @(posedge pclk);
        rd_chk("window", `REG_STATUS, 32'h20, 32'h20);
        while (cycles - c0 < 240) @(posedge pclk);
        rd_chk("steady", `REG_STATUS, 32'h28, 32'h08);
        apb(1'b0, `REG_TIMER, 32'h0);
        t0 = rd;
        apb(1'b0, `REG_TIMER, 32'h0);
        check("timer", {31'h0, rd != t0}, 32'h1);
        apb(1'b0, `REG_CYCLES, 32'h0);
        check("cycles", {31'h0, rd != 0}, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h10);
        bp_en <= 1'b1;
        wait_mode(`MODE_HOLD);
        check("hold", {28'h0, inh, stop_ind, vis, tmr}, 32'he);
        g = toggles;
        repeat (30) @(posedge pclk);
        check("hold_blink", {31'h0, toggles > g}, 32'h1);
        apb(1'b0, `REG_TIMER, 32'h0);
        t0 = rd;
        rd_chk("frozen", `REG_TIMER, 32'hffffffff, t0);
        apb(1'b0, `REG_RTC, 32'h0);
        t0 = rd;
        apb(1'b0, `REG_RTC, 32'h0);
        check("rtc", {31'h0, rd != t0}, 32'h1);
        g = grants;
        apb(1'b1, `REG_CTRL, 32'h14);
        repeat (3) @(posedge pclk);
        check("step", grants, g + 1);
        apb(1'b1, `REG_BPCOUNT, 32'h3);
        apb(1'b1, `REG_CTRL, 32'h14);
        repeat (3) @(posedge pclk);
        check("refused", grants, g + 1);
        rd_chk("ref_flag", `REG_STATUS, 32'h40, 32'h40);
        apb(1'b1, `REG_STATUS, 32'h40);
        rd_chk("ref_clr", `REG_STATUS, 32'h40, 32'h0);
        bp_en <= 1'b0;
        apb(1'b1, `REG_CTRL, 32'h18);
        wait_mode(`MODE_RUN);
        check("resume", {30'h0, inh, tmr}, 32'h1);
        error_detect <= 1'b1;
        @(posedge pclk);
        error_detect <= 1'b0;
        wait_mode(`MODE_STOP);
        apb(1'b0, `REG_TIMER, 32'h0);
        t0 = rd;
        check("kept", {31'h0, t0 != 0}, 32'h1);
        rd_chk("kept2", `REG_TIMER, 32'hffffffff, t0);
        apb(1'b1, `REG_CTRL, 32'h1);
        wait_mode(`MODE_STARTUP);
        apb(1'b1, `REG_CTRL, 32'h2);
        wait_mode(`MODE_STOP);
        rd_chk("stop_blink", `REG_STATUS, 32'h37, 32'h34);
        g = toggles;
        repeat (30) @(posedge pclk);
        check("stop_tog", {31'h0, toggles > g}, 32'h1);
        end_of_test();
    end
endmodule // tb
